// File: rtl/dram_pin_pkg.sv
package dram_pin_pkg;
    // Burst beats per READ or WRITE, one word per link clock
    localparam int BURST_BEATS = 4;
    localparam int LANE_BITS = 8;
    localparam int LANES = 2;
    localparam int DATA_BITS = LANE_BITS * LANES;
    localparam int BANKS = 8;
    // Command codes on {row, column, write} strobes
    localparam logic [2:0] CMD_MODE = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_NOP = 3'h7;
    // Mode register select and termination field positions
    localparam logic [2:0] MODE_REG_TERM = 3'h1;
    localparam int TERM_BIT_A = 2;
    localparam int TERM_BIT_B = 6;
    localparam int TERM_BIT_C = 9;
    localparam int ALL_BANKS_BIT = 10;
    localparam logic TERM_EN_RESET = 1'b0;

    typedef struct packed {
        logic cs_n;
        logic [2:0] cmd;
        logic [2:0] bank;
        logic [14:0] addr;
    } link_cmd_t;

    // Input receiver enables, one per pin group
    typedef struct packed {
        logic clock;
        logic gate;
        logic reset;
        logic term;
        logic cmd_addr;
        logic data;
    } buf_en_t;

    localparam buf_en_t BUF_ALL_ON = 6'h3f;
    localparam buf_en_t BUF_POWER_DOWN = 6'h3c;
    localparam buf_en_t BUF_SELF_REFRESH = 6'h18;

    typedef struct packed {
        logic [DATA_BITS-1:0] data;
        logic [LANES-1:0] keep;
    } wr_word_t;

    typedef enum logic [1:0] {P_ACTIVE, P_PD_PRE, P_PD_ACT, P_SELF} pwr_t;
endpackage

// File: rtl/cross_buf2.sv
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer across clocks, gray pointers through two flops
module cross_buf2 #(
    parameter int WIDTH = 18,
    parameter int ADDR_BITS = 1
) (
    input wire logic arst_n,
    input wire logic wr_clk,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic rd_clk,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = ADDR_BITS + 1;
    localparam logic [PW-1:0] DEPTH = PW'(1 << ADDR_BITS);

    function automatic logic [PW-1:0] gray_to_bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = g;
        // Top bit passes through; no index past the top is touched
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = g[i] ^ b[i + 1];
        end
        return b;
    endfunction

    logic [WIDTH-1:0] mem [0:(1 << ADDR_BITS)-1];
    logic [PW-1:0] wbin_r, wgray_r, rbin_r, rgray_r;
    logic [PW-1:0] rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;

    assign in_ready = (wbin_r - gray_to_bin(rg_s2_r)) != DEPTH;
    assign out_valid = rbin_r != gray_to_bin(wg_s2_r);
    assign out_data = mem[rbin_r[ADDR_BITS-1:0]];

    ////////////////////////////////////////////////////////////////
    // Write side; storage has no reset, pointers guard it
    always_ff @(posedge wr_clk) begin
        if (in_valid && in_ready) begin
            mem[wbin_r[ADDR_BITS-1:0]] <= in_data;
        end
    end

    always_ff @(posedge wr_clk or negedge arst_n) begin
        if (!arst_n) begin
            wbin_r <= '0;
            wgray_r <= '0;
            rg_s1_r <= '0;
            rg_s2_r <= '0;
        end else begin
            rg_s1_r <= rgray_r;
            rg_s2_r <= rg_s1_r;
            if (in_valid && in_ready) begin
                wbin_r <= wbin_r + PW'(1);
                wgray_r <= (wbin_r + PW'(1)) ^ ((wbin_r + PW'(1)) >> 1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read side
    always_ff @(posedge rd_clk or negedge arst_n) begin
        if (!arst_n) begin
            rbin_r <= '0;
            rgray_r <= '0;
            wg_s1_r <= '0;
            wg_s2_r <= '0;
        end else begin
            wg_s1_r <= wgray_r;
            wg_s2_r <= wg_s1_r;
            if (out_valid && out_ready) begin
                rbin_r <= rbin_r + PW'(1);
                rgray_r <= (rbin_r + PW'(1)) ^ ((rbin_r + PW'(1)) >> 1);
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/dram_pin_ctrl.sv
// Behaviour
// R1: Registered gate high enables internal clocks and logic; low disables them.
// R2: Gate low enters precharge power-down or self refresh if idle, else active power-down; here REFRESH enters self refresh even with rows open.
// R3: Gate is sampled on the clock for power-down entry, exit and self refresh entry.
// R4: Gate high ends self refresh without any clock edge; here receivers wake at once but pwr_state leaves P_SELF on a clock edge.
// R5: Power-down keeps only clock, gate, reset and termination receivers on.
// R6: Self refresh keeps only gate and reset receivers on.
// R7: Control and address are sampled on the rising clock crossing.
// R8: Read strobes are timed from the link clock.
// R9: Select low enables command decode; select high masks every command.
// R10: Registered termination input switches internal termination on and off.
// R11: Termination disabled by mode load makes the termination input ignored.
// R12: Device drives strobes on reads; controller drives them on writes.
// R13: Read strobe edges align with data; write strobes sit mid-eye.
// R14: Strobes are always true and complement pairs, never single-ended.
// R15: A write byte whose mask is sampled high is discarded.
// R16: Data splits into lower and upper lanes, each with strobe and mask.
// R17: Command decodes from row, column, write strobes and select.
// R18: Active-low reset acts on assertion and release without the clock.
`timescale 1ns/1ps
`default_nettype none
module dram_pin_ctrl import dram_pin_pkg::*; (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic dram_diff_clock_ball,
    input wire logic dram_clock_gate_ball,
    input wire logic dram_select_ball_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_en_n,
    input wire logic [2:0] bank_ball,
    input wire logic [14:0] addr_ball,
    input wire logic dram_termination_ball,
    input wire logic [DATA_BITS-1:0] dq_i,
    output logic [DATA_BITS-1:0] dq_o,
    output logic [DATA_BITS-1:0] dq_oe,
    input wire logic dram_lower_strobe_ball_i,
    input wire logic dram_lower_strobe_ball_c_i,
    output logic dram_lower_strobe_ball_o,
    output logic dram_lower_strobe_ball_c_o,
    output logic dram_lower_strobe_ball_oe,
    input wire logic dram_upper_strobe_ball_i,
    input wire logic dram_upper_strobe_ball_c_i,
    output logic dram_upper_strobe_ball_o,
    output logic dram_upper_strobe_ball_c_o,
    output logic dram_upper_strobe_ball_oe,
    input wire logic dram_lower_mask_ball,
    input wire logic dram_upper_mask_ball,
    output logic core_clk_en,
    output buf_en_t buf_en,
    output logic term_on,
    output pwr_t pwr_state,
    output logic cmd_valid,
    output link_cmd_t cmd_out,
    output logic wr_valid,
    input wire logic wr_ready,
    output wr_word_t wr_word,
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [DATA_BITS-1:0] rd_data
);
    localparam logic [2:0] BEATS = 3'(BURST_BEATS);

    function automatic logic lane_valid(input logic t, input logic c);
        return t != c;
    endfunction

    wire ck = dram_diff_clock_ball;
    link_cmd_t cmd_q;
    logic gate_q, term_q;
    logic [1:0] mask_q;
    logic [DATA_BITS-1:0] dq_q;
    logic [1:0] strobe_ok_q;
    pwr_t st_r;
    logic [BANKS-1:0] open_r;
    logic term_en_r, term_on_r;
    logic [2:0] wr_left_r, rd_left_r;
    wr_word_t beat_r;
    logic beat_v_r;
    logic beat_ready;
    logic [DATA_BITS-1:0] rdq_r;
    logic drive_r, phase_r;
    logic cmd_fire, sre, sref_live, pop;
    logic [DATA_BITS-1:0] rfifo_data;
    logic rfifo_valid;

    ////////////////////////////////////////////////////////////////
    // Pin capture on the rising crossing of the link clock
    always_ff @(posedge ck or negedge arst_n) begin
        if (!arst_n) begin // [R18]
            cmd_q <= '{cs_n: 1'b1, cmd: CMD_NOP, bank: 3'h0, addr: 15'h0000};
            gate_q <= 1'b0;
            term_q <= 1'b0;
        end else begin
            cmd_q <= '{cs_n: dram_select_ball_n, cmd: {row_strobe_n, col_strobe_n, write_en_n}, // [R7] [R17]
                       bank: bank_ball, addr: addr_ball};
            gate_q <= dram_clock_gate_ball; // [R3]
            term_q <= dram_termination_ball;
        end
    end

    // Data, masks and strobe validity sampled per beat
    always_ff @(posedge ck or negedge arst_n) begin
        if (!arst_n) begin
            dq_q <= '0;
            mask_q <= 2'h3;
            strobe_ok_q <= 2'h0;
        end else begin
            dq_q <= dq_i;
            mask_q <= {dram_upper_mask_ball, dram_lower_mask_ball}; // [R16]
            strobe_ok_q <= {lane_valid(dram_upper_strobe_ball_i, dram_upper_strobe_ball_c_i), // [R14]
                            lane_valid(dram_lower_strobe_ball_i, dram_lower_strobe_ball_c_i)};
        end
    end

    ////////////////////////////////////////////////////////////////
    // Decode only while awake and selected
    assign cmd_fire = st_r == P_ACTIVE && gate_q && !cmd_q.cs_n && cmd_q.cmd != CMD_NOP; // [R1] [R9]
    assign sre = st_r == P_ACTIVE && !gate_q && !cmd_q.cs_n && cmd_q.cmd == CMD_REFRESH;
    assign cmd_valid = cmd_fire;
    assign cmd_out = cmd_q;
    assign core_clk_en = gate_q && st_r == P_ACTIVE; // [R1]

    // Self refresh receivers wake the moment the gate pin rises; pwr_state leaves P_SELF only on a clock edge
    assign sref_live = st_r == P_SELF && !dram_clock_gate_ball; // [R4]
    assign pwr_state = st_r;

    // Receiver enables per power state
    always_comb begin
        if (sref_live) begin
            buf_en = BUF_SELF_REFRESH; // [R6]
        end else if (st_r == P_PD_PRE || st_r == P_PD_ACT) begin
            buf_en = BUF_POWER_DOWN; // [R5]
        end else begin
            buf_en = BUF_ALL_ON;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Power state
    always_ff @(posedge ck or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= P_ACTIVE;
        end else begin
            unique case (st_r)
                P_ACTIVE: begin
                    if (sre) begin
                        st_r <= P_SELF; // [R2]
                    end else if (!gate_q) begin
                        st_r <= (open_r == '0) ? P_PD_PRE : P_PD_ACT; // [R2] [R3]
                    end
                end
                P_PD_PRE, P_PD_ACT, P_SELF: begin
                    if (gate_q) begin
                        st_r <= P_ACTIVE; // [R3]
                    end
                end
            endcase
        end
    end

    // Open rows per bank
    always_ff @(posedge ck or negedge arst_n) begin
        if (!arst_n) begin
            open_r <= '0;
        end else if (cmd_fire && cmd_q.cmd == CMD_ACTIVATE) begin
            open_r[cmd_q.bank] <= 1'b1;
        end else if (cmd_fire && cmd_q.cmd == CMD_PRECHARGE) begin
            if (cmd_q.addr[ALL_BANKS_BIT]) begin
                open_r <= '0;
            end else begin
                open_r[cmd_q.bank] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Termination; receiver off in self refresh, so no effect there
    always_ff @(posedge ck or negedge arst_n) begin
        if (!arst_n) begin
            term_en_r <= TERM_EN_RESET;
            term_on_r <= 1'b0;
        end else begin
            if (cmd_fire && cmd_q.cmd == CMD_MODE && cmd_q.bank == MODE_REG_TERM) begin
                term_en_r <= cmd_q.addr[TERM_BIT_A] | cmd_q.addr[TERM_BIT_B] | cmd_q.addr[TERM_BIT_C];
            end
            term_on_r <= term_q && term_en_r && st_r != P_SELF; // [R10] [R11]
        end
    end
    assign term_on = term_on_r;

    ////////////////////////////////////////////////////////////////
    // Write beats; a held beat stalls capture so it is not overwritten, and pin beats arriving meanwhile are missed
    logic wbuf_in_ready;
    assign beat_ready = !beat_v_r || wbuf_in_ready;

    always_ff @(posedge ck or negedge arst_n) begin
        if (!arst_n) begin
            wr_left_r <= 3'h0;
            beat_v_r <= 1'b0;
            beat_r <= '0;
        end else begin
            if (beat_v_r && wbuf_in_ready) begin
                beat_v_r <= 1'b0;
            end
            if (cmd_fire && cmd_q.cmd == CMD_WRITE) begin
                wr_left_r <= BEATS;
            end else if (wr_left_r != 3'h0 && beat_ready && strobe_ok_q == 2'h3) begin // [R12] [R13]
                wr_left_r <= wr_left_r - 3'h1;
                // Fully masked beats are dropped here, partial ones carry keep
                if (mask_q != 2'h3) begin // [R15]
                    beat_v_r <= 1'b1;
                    beat_r.keep <= ~mask_q; // [R15] [R16]
                    beat_r.data <= {mask_q[1] ? 8'h00 : dq_q[15:8], mask_q[0] ? 8'h00 : dq_q[7:0]};
                end
            end
        end
    end

    cross_buf2 #(.WIDTH($bits(wr_word_t)), .ADDR_BITS(1)) u_wbuf (
        .arst_n(arst_n),
        .wr_clk(ck),
        .in_valid(beat_v_r),
        .in_ready(wbuf_in_ready),
        .in_data(beat_r),
        .rd_clk(clk_sys),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_word)
    );

    ////////////////////////////////////////////////////////////////
    // Read beats from the core, driven out on the link clock
    cross_buf2 #(.WIDTH(DATA_BITS), .ADDR_BITS(1)) u_rbuf (
        .arst_n(arst_n),
        .wr_clk(clk_sys),
        .in_valid(rd_valid),
        .in_ready(rd_ready),
        .in_data(rd_data),
        .rd_clk(ck),
        .out_valid(rfifo_valid),
        .out_ready(pop),
        .out_data(rfifo_data)
    );

    assign pop = rd_left_r != 3'h0 && rfifo_valid;

    // Data and strobe share one flop edge, so edges line up
    always_ff @(posedge ck or negedge arst_n) begin
        if (!arst_n) begin
            rd_left_r <= 3'h0;
            rdq_r <= '0;
            drive_r <= 1'b0;
            phase_r <= 1'b0;
        end else begin
            if (cmd_fire && cmd_q.cmd == CMD_READ) begin
                rd_left_r <= BEATS;
            end else if (pop) begin
                rd_left_r <= rd_left_r - 3'h1;
            end
            drive_r <= rd_left_r != 3'h0 && wr_left_r == 3'h0; // [R12]
            if (pop) begin
                rdq_r <= rfifo_data; // [R13]
                phase_r <= ~phase_r; // [R8]
            end
        end
    end

    assign dq_o = rdq_r;
    assign dq_oe = {DATA_BITS{drive_r}};
    assign dram_lower_strobe_ball_o = phase_r;
    assign dram_lower_strobe_ball_c_o = ~phase_r; // [R14]
    assign dram_lower_strobe_ball_oe = drive_r;
    assign dram_upper_strobe_ball_o = phase_r;
    assign dram_upper_strobe_ball_c_o = ~phase_r; // [R14]
    assign dram_upper_strobe_ball_oe = drive_r;

    ////////////////////////////////////////////////////////////////
    // Checks on the link clock
    default clocking cb @(posedge ck); endclocking
    default disable iff (!arst_n);

    cmd_mask_a: assert property (cmd_q.cs_n |-> !cmd_valid) else $error("masked command decoded"); // [R9]
    term_ignore_a: assert property (!term_en_r |=> !term_on) else $error("termination on while disabled"); // [R11]
    term_follow_a: assert property (term_q && term_en_r && st_r == P_ACTIVE |=> term_on)
        else $error("termination did not follow input"); // [R10]
    pd_bufs_a: assert property (st_r == P_PD_PRE || st_r == P_PD_ACT |-> buf_en == BUF_POWER_DOWN)
        else $error("wrong receivers in power-down"); // [R5]
    sr_bufs_a: assert property (st_r == P_SELF && !dram_clock_gate_ball |-> buf_en == BUF_SELF_REFRESH)
        else $error("wrong receivers in self refresh"); // [R6]
    pd_entry_a: assert property (st_r == P_ACTIVE && !gate_q && !sre && open_r == '0 |=> st_r == P_PD_PRE)
        else $error("idle power-down not entered"); // [R2]
    strobe_pair_a: assert property (dram_lower_strobe_ball_oe |-> dram_lower_strobe_ball_o != dram_lower_strobe_ball_c_o)
        else $error("strobe pair not complementary"); // [R14]
    read_dir_a: assert property ($rose(drive_r) |-> $past(wr_left_r) == 3'h0) else $error("strobes driven during write"); // [R12]
    read_edge_a: assert property (pop |=> phase_r != $past(phase_r) && dq_o == $past(rfifo_data))
        else $error("read strobe not aligned to data"); // [R13]
    mask_drop_a: assert property ($rose(beat_v_r) |-> beat_r.keep == ~$past(mask_q) && beat_r.keep != 2'h0)
        else $error("masked byte kept"); // [R15]
    gate_off_a: assert property (!gate_q |-> !core_clk_en ##1 st_r != P_ACTIVE || gate_q)
        else $error("gate low did not stop the core"); // [R1]
endmodule
`default_nettype wire

// File: testbench/dram_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dram_host_model import dram_pin_pkg::*; (
    output logic ck,
    output logic gate,
    output link_cmd_t pins,
    output logic odt,
    output logic [DATA_BITS-1:0] dq,
    output logic [LANES-1:0] stb_t,
    output logic [LANES-1:0] stb_c,
    output logic [LANES-1:0] mask
);
    // Link clock runs free, as the gate is sampled even when idle
    initial begin
        ck = 1'b0;
        #7;
        forever #15 ck = ~ck;
    end

    // Idle pins: gate high, deselected, strobe pair parked equal
    initial begin
        gate = 1'b1;
        pins = {1'b1, CMD_NOP, 3'h0, 15'h0000};
        odt = 1'b0;
        dq = 16'h0000;
        stb_t = 2'h0;
        stb_c = 2'h0;
        mask = 2'h0;
    end

    // Level pins set by the bench between commands, one driver each
    task automatic levels(input logic g, input logic o);
        gate <= g;
        odt <= o;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Pins change after a falling edge and hold across one rising edge
    task automatic send(input logic g, input logic sel_n, input logic [2:0] code,
                        input logic [2:0] bk, input logic [14:0] ad);
        @(negedge ck);
        gate <= g;
        pins <= {sel_n, code, bk, ad};
        @(negedge ck);
        pins <= {1'b1, CMD_NOP, bk, ad};
    endtask

    // Write beats; slow puts an equal strobe pair (no beat) between them
    task automatic beats(input logic [63:0] d, input logic [7:0] m, input logic slow);
        for (int i = 0; i < BURST_BEATS; i++) begin
            if (slow) begin
                stb_c <= stb_t;
                @(negedge ck);
            end
            dq <= d[16*i +: 16];
            mask <= m[2*i +: 2];
            stb_t <= ~stb_t;
            stb_c <= stb_t;
            @(negedge ck);
        end
        // Released lines must not keep the last value
        dq <= ~dq;
        stb_c <= stb_t;
    endtask
endmodule
`default_nettype wire

// File: testbench/ddr3_control_pin_behaviour_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ddr3_control_pin_behaviour_bench import dram_pin_pkg::*;;
    logic clk_sys, arst_n, ck, gate, odt, wr_ready, rd_valid;
    link_cmd_t pins, cmd_out;
    logic [DATA_BITS-1:0] hdq, dq_i, dq_o, dq_oe, rd_data;
    logic [LANES-1:0] stb_t, stb_c, mask;
    logic lo_o, lo_c, lo_oe, up_o, up_c, up_oe, core_clk_en, term_on, cmd_valid, wr_valid, rd_ready;
    buf_en_t buf_en;
    pwr_t pwr_state;
    wr_word_t wr_word;
    int mismatches = 0;
    int comparisons = 0;

    // Wire level of each data line from both drivers
    assign dq_i = (dq_oe & dq_o) | (~dq_oe & hdq);

    dram_host_model host (.ck(ck), .gate(gate), .pins(pins), .odt(odt), .dq(hdq), .stb_t(stb_t),
        .stb_c(stb_c), .mask(mask));

    dram_pin_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n), .dram_diff_clock_ball(ck),
        .dram_clock_gate_ball(gate), .dram_select_ball_n(pins.cs_n), .row_strobe_n(pins.cmd[2]),
        .col_strobe_n(pins.cmd[1]), .write_en_n(pins.cmd[0]), .bank_ball(pins.bank),
        .addr_ball(pins.addr), .dram_termination_ball(odt), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
        .dram_lower_strobe_ball_i(lo_oe ? lo_o : stb_t[0]), .dram_lower_strobe_ball_c_i(lo_oe ? lo_c : stb_c[0]),
        .dram_lower_strobe_ball_o(lo_o), .dram_lower_strobe_ball_c_o(lo_c), .dram_lower_strobe_ball_oe(lo_oe),
        .dram_upper_strobe_ball_i(up_oe ? up_o : stb_t[1]), .dram_upper_strobe_ball_c_i(up_oe ? up_c : stb_c[1]),
        .dram_upper_strobe_ball_o(up_o), .dram_upper_strobe_ball_c_o(up_c), .dram_upper_strobe_ball_oe(up_oe),
        .dram_lower_mask_ball(mask[0]), .dram_upper_mask_ball(mask[1]), .core_clk_en(core_clk_en),
        .buf_en(buf_en), .term_on(term_on), .pwr_state(pwr_state), .cmd_valid(cmd_valid), .cmd_out(cmd_out),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data));

    // Core clock, 40 ns
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic ck_n(input int n);
        repeat (n) @(negedge ck);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(24'({pwr_state, buf_en}), 24'({P_ACTIVE, BUF_ALL_ON}));
        chk(24'({dq_oe, lo_oe, up_oe, term_on, core_clk_en}), 24'h00_0000);
    endtask

    // Mode, refresh, precharge and activate each decode when selected, and none when deselected
    task automatic t_decode();
        logic [2:0] codes [4] = '{CMD_MODE, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVATE};
        for (int i = 0; i < 4; i++) begin
            host.send(1'b1, 1'b0, codes[i], 3'(i), 15'h1234 + 15'(i));
            #1;
            chk({core_clk_en, cmd_valid, cmd_out}, {3'b110, codes[i], 3'(i), 15'h1234 + 15'(i)});
            host.send(1'b1, 1'b1, codes[i], 3'(i), 15'h0000);
            #1;
            chk(24'(cmd_valid), 24'h00_0000);
        end
    endtask

    // Each enable bit of the mode load; clearing it masks the input
    task automatic t_term();
        int bits [3] = '{TERM_BIT_A, TERM_BIT_B, TERM_BIT_C};
        host.levels(1'b1, 1'b1);
        ck_n(3);
        chk(24'(term_on), 24'h00_0000);
        for (int i = 0; i < 3; i++) begin
            host.send(1'b1, 1'b0, CMD_MODE, MODE_REG_TERM, 15'h0001 << bits[i]);
            ck_n(3);
            chk(24'(term_on), 24'h00_0001);
            host.levels(1'b1, 1'b0);
            ck_n(3);
            chk(24'(term_on), 24'h00_0000);
            host.levels(1'b1, 1'b1);
            host.send(1'b1, 1'b0, CMD_MODE, MODE_REG_TERM, 15'h0000);
            ck_n(3);
            chk(24'(term_on), 24'h00_0000);
        end
        host.send(1'b1, 1'b0, CMD_MODE, MODE_REG_TERM, 15'h0001 << TERM_BIT_A);
    endtask

    task automatic t_power();
        host.send(1'b1, 1'b0, CMD_PRECHARGE, 3'h0, 15'h0400);
        host.send(1'b0, 1'b1, CMD_NOP, 3'h0, 15'h0000);
        ck_n(3);
        chk(24'({pwr_state, buf_en, core_clk_en}), 24'({P_PD_PRE, BUF_POWER_DOWN, 1'b0}));
        host.send(1'b0, 1'b0, CMD_ACTIVATE, 3'h1, 15'h0000);
        #1;
        chk(24'(cmd_valid), 24'h00_0000);
        host.send(1'b1, 1'b1, CMD_NOP, 3'h0, 15'h0000);
        ck_n(3);
        chk(24'({pwr_state, buf_en, core_clk_en}), 24'({P_ACTIVE, BUF_ALL_ON, 1'b1}));
        // Open row, so the same entry lands in active power-down
        host.send(1'b1, 1'b0, CMD_ACTIVATE, 3'h2, 15'h0010);
        host.send(1'b0, 1'b1, CMD_NOP, 3'h0, 15'h0000);
        ck_n(3);
        chk(24'({pwr_state, buf_en}), 24'({P_PD_ACT, BUF_POWER_DOWN}));
        host.send(1'b1, 1'b1, CMD_NOP, 3'h0, 15'h0000);
        ck_n(3);
        host.send(1'b1, 1'b0, CMD_PRECHARGE, 3'h0, 15'h0400);
        host.send(1'b0, 1'b0, CMD_REFRESH, 3'h0, 15'h0000);
        ck_n(3);
        chk(24'({pwr_state, buf_en, term_on}), 24'({P_SELF, BUF_SELF_REFRESH, 1'b0}));
        // Exit between edges: receivers must wake without a clock edge
        #5;
        host.levels(1'b1, 1'b1);
        #1;
        chk(24'(buf_en), 24'(BUF_ALL_ON));
        ck_n(4);
        chk(24'({pwr_state, term_on}), 24'({P_ACTIVE, 1'b1}));
    endtask

    // Slow beats, one dropped, receiver stalled until the buffer is full
    task automatic t_write();
        wr_word_t exp [3] = '{{16'ha1b2, 2'b11}, {16'hc300, 2'b10}, {16'h00e4, 2'b01}};
        int n = 0;
        @(negedge clk_sys);
        wr_ready <= 1'b0;
        host.send(1'b1, 1'b0, CMD_WRITE, 3'h0, 15'h0008);
        host.beats({16'h55e4, 16'hc3d4, 16'h7777, 16'ha1b2}, {2'b10, 2'b01, 2'b11, 2'b00}, 1'b1);
        chk(24'({dq_oe, lo_oe, up_oe}), 24'h00_0000);
        repeat (10) @(negedge clk_sys);
        chk(24'({wr_valid, wr_word}), 24'({1'b1, exp[0]}));
        // Look at each word while it stands, before the edge that takes it
        wr_ready <= 1'b1;
        repeat (40) begin
            if (wr_valid === 1'b1) begin
                chk(24'(wr_word), 24'(exp[n % 3]));
                n++;
            end
            @(negedge clk_sys);
        end
        chk(24'(n), 24'h00_0003);
    endtask

    // Feeder on the core side, strobe watcher on the link side
    task automatic t_read();
        logic [15:0] got [$];
        logic last;
        logic [15:0] exp [4] = '{16'h1111, 16'h2c3d, 16'hfe01, 16'h8080};
        fork
            begin
                for (int i = 0; i < 4; i++) begin
                    @(negedge clk_sys);
                    rd_valid <= 1'b1;
                    rd_data <= exp[i];
                    for (int k = 0; k < 50; k++) begin
                        @(posedge clk_sys);
                        if (rd_ready === 1'b1) break;
                        if (k == 49) mismatches++;
                    end
                end
                @(negedge clk_sys);
                rd_valid <= 1'b0;
            end
            begin
                host.send(1'b1, 1'b0, CMD_READ, 3'h0, 15'h0010);
                last = lo_o;
                for (int k = 0; k < 80 && got.size() < 4; k++) begin
                    @(negedge ck);
                    if (lo_oe === 1'b1) begin
                        chk(24'({lo_c, up_c, up_o, up_oe, dq_oe}), 24'({~lo_o, ~lo_o, lo_o, 1'b1, 16'hffff}));
                        if (lo_o !== last) got.push_back(dq_o);
                        last = lo_o;
                    end
                end
            end
        join
        for (int i = 0; i < 4; i++) chk(24'(got[i]), 24'(exp[i]));
        ck_n(6);
        chk(24'({dq_oe, lo_oe, up_oe}), 24'h00_0000);
    endtask

    // Reset between clock edges, while termination is on
    task automatic t_reset_mid();
        chk(24'(term_on), 24'h00_0001);
        @(negedge clk_sys);
        arst_n = 1'b0;
        #1;
        chk(24'({pwr_state, term_on, lo_oe, cmd_valid, wr_valid}), 24'({P_ACTIVE, 4'h0}));
        repeat (2) @(negedge clk_sys);
        arst_n <= 1'b1;
        ck_n(4);
        chk(24'(term_on), 24'h00_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        wr_ready = 1'b1;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
        repeat (10) @(negedge clk_sys);
        t_reset();
        repeat (10) @(negedge clk_sys);
        arst_n <= 1'b1;
        ck_n(3);
        t_decode();
        t_term();
        t_power();
        t_write();
        t_read();
        t_reset_mid();
        print_verdict();
    end

    // Hang guard
    initial begin
        #2_000_000;
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
